// file: hdl/change_detect_consts.vh
// What this block does
// RL1 - Thirty-two process inputs are sampled and any change of level can raise an alarm.
// RL2 - Three modes exist: no alarm, alarm on the interrupt line, alarm in the first input byte.
// RL3 - The input filter reaction time is selected as 0.3 ms, 1 ms or 3 ms.
// RL4 - A shorter reaction time filters less, so short glitches may pass as real changes.
// RL5 - For the first-byte alarm the host maps the device at byte address 128 or above.
// RL6 - Any read of an input byte acknowledges a pending alarm.
// RL7 - The first-byte alarm is only possible while the device sits in the standard window.
// RL8 - In interrupt-line mode the host places the device only where an interrupt line exists.
// RL9 - The host treats the alarm request as a level and services it while it stays high.
// RL10 - The host does not let further alarms preempt its alarm handler routine.
// RL11 - The host reads the inputs only in the handler and works on a copy elsewhere.
// RL12 - In the mode with no alarm the edge select switches are ignored.
// RL13 - Per input byte a pair of edge select switches picks rising and/or falling edges.
// RL14 - Reading the first input byte freezes the inputs and reading the fourth releases them.
// RL15 - The alarm request stays high from the change until the host reads the inputs.
`ifndef CHANGE_DETECT_CONSTS_VH
`define CHANGE_DETECT_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_IN0        8'h00
`define OFF_IN1        8'h04
`define OFF_IN2        8'h08
`define OFF_IN3        8'h0c
`define OFF_CTRL       8'h10
`define OFF_EDGE       8'h14
`define OFF_STATUS     8'h18
`define OFF_IRQ_EN     8'h1c
`define OFF_IRQ_CLR    8'h20
`define OFF_ALARM      8'h24

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CTRL_MODE_LO   0
`define CTRL_MODE_HI   1
`define CTRL_REACT_LO  2
`define CTRL_REACT_HI  3
`define CTRL_STD_AREA  4
`define MODE_NONE      2'h0
`define MODE_IRQ_LINE  2'h1
`define MODE_FIRST_BYTE 2'h2
`define REACT_SHORT    2'h0
`define REACT_MID      2'h1
`define REACT_LONG     2'h2
`define ST_CHANGE      0
`define ST_ACK         1
`define ST_ALARM       2
`define FIRST_BYTE_FLAG 8'hff

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RESET     5'h00
`define EDGE_RESET     8'h55
`define IRQ_EN_RESET   3'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_MHZ        50
`define REACT_SHORT_US 300
`define REACT_MID_US   1000
`define REACT_LONG_US  3000
// sized to the 18-bit filter counters: the _US values times CLK_MHZ
`define REACT_SHORT_CYC 18'h03a98
`define REACT_MID_CYC   18'h0c350
`define REACT_LONG_CYC  18'h249f0

`endif

// file: hdl/change_detect_input_module.v
`timescale 1ns/1ns
`include "change_detect_consts.vh"

module change_detect_input_module #(
    parameter [17:0] react_short_cyc = `REACT_SHORT_CYC,
    parameter [17:0] react_mid_cyc   = `REACT_MID_CYC,
    parameter [17:0] react_long_cyc  = `REACT_LONG_CYC
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [31:0] process_in,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg         alarm_req,
    output reg         irq
);

// ----------------------------------------------------------------
// decode helpers
// ----------------------------------------------------------------
function is_input_byte;
    input [7:0] a;
    begin
        is_input_byte = (a == `OFF_IN0) || (a == `OFF_IN1) ||
                        (a == `OFF_IN2) || (a == `OFF_IN3);
    end
endfunction

function is_mapped;
    input [7:0] a;
    begin
        is_mapped = is_input_byte(a) || (a == `OFF_CTRL) ||
                    (a == `OFF_EDGE) || (a == `OFF_STATUS) ||
                    (a == `OFF_IRQ_EN) || (a == `OFF_IRQ_CLR) ||
                    (a == `OFF_ALARM);
    end
endfunction

// ----------------------------------------------------------------
// state
// ----------------------------------------------------------------
reg  [4:0]  ctrl;
reg  [7:0]  edge_select_switches;
reg  [2:0]  status;
reg  [2:0]  irq_en;
reg         frozen;
reg         pending;
reg  [31:0] stable;
reg  [31:0] prev;
reg  [7:0]  aw_addr;
reg         aw_held;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg         w_held;
reg  [17:0] react_lim;
reg         next_pending;
reg  [2:0]  next_status;
reg  [31:0] rd_val;

wire [1:0]  mode     = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
wire [1:0]  react    = ctrl[`CTRL_REACT_HI:`CTRL_REACT_LO];
wire        std_area = ctrl[`CTRL_STD_AREA];
wire        rd_take  = s_axi_arvalid && s_axi_arready;
wire        wr_fire  = aw_held && w_held && !s_axi_bvalid;
wire        in_read  = rd_take && is_input_byte(s_axi_araddr);
wire [31:0] rise     = stable & ~prev;
wire [31:0] fall     = ~stable & prev;
wire        any_change = |(stable ^ prev);
wire [3:0]  byte_hit;

// ----------------------------------------------------------------
// input filter
// ----------------------------------------------------------------
// shorter limits mean less interference rejection by design
always @* begin
    case (react) // RL3 RL4
        `REACT_SHORT: react_lim = react_short_cyc;
        `REACT_MID:   react_lim = react_mid_cyc;
        `REACT_LONG:  react_lim = react_long_cyc;
        default:      react_lim = react_long_cyc;
    endcase
end

genvar i;
generate
    for (i = 0; i < 32; i = i + 1) begin : chan
        reg [17:0] cnt;
        always @(posedge aclk) begin
            if (!aresetn) begin
                cnt       <= 18'h00000;
                stable[i] <= 1'b0;
            end else if (process_in[i] == stable[i]) begin
                cnt <= 18'h00000;
            end else if (frozen) begin // RL14
                cnt <= cnt;
            end else if (cnt >= react_lim - 18'h00001) begin // RL1
                cnt       <= 18'h00000;
                stable[i] <= process_in[i];
            end else begin
                cnt <= cnt + 18'h00001;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// per-byte edge select
// ----------------------------------------------------------------
genvar b;
generate
    for (b = 0; b < 4; b = b + 1) begin : byte_edge
        // even switch enables rising, odd switch falling
        assign byte_hit[b] =
            |((rise[b*8+7:b*8] & {8{edge_select_switches[2*b]}}) |
              (fall[b*8+7:b*8] & {8{edge_select_switches[2*b+1]}})); // RL13
    end
endgenerate

// ----------------------------------------------------------------
// alarm
// ----------------------------------------------------------------
always @* begin
    next_pending = pending;
    if (in_read) begin
        next_pending = 1'b0; // RL6
    end
    // set wins over the acknowledge in the same cycle
    if (|byte_hit && mode != `MODE_NONE && // RL12
        (mode != `MODE_FIRST_BYTE || std_area)) begin // RL7
        next_pending = 1'b1; // RL2 RL15
    end
end

always @* begin
    next_status = status;
    if (wr_fire && aw_addr == `OFF_IRQ_CLR && w_strb[0]) begin
        next_status = status & ~w_data[2:0];
    end
    if (any_change) begin
        next_status[`ST_CHANGE] = 1'b1;
    end
    if (in_read && pending) begin
        next_status[`ST_ACK] = 1'b1;
    end
    if (next_pending && !pending) begin
        next_status[`ST_ALARM] = 1'b1;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        prev      <= 32'h00000000;
        pending   <= 1'b0;
        frozen    <= 1'b0;
        status    <= 3'h0;
        alarm_req <= 1'b0;
        irq       <= 1'b0;
    end else begin
        prev      <= stable;
        pending   <= next_pending;
        status    <= next_status;
        alarm_req <= next_pending && (mode == `MODE_IRQ_LINE); // RL15
        irq       <= |(next_status & irq_en);
        if (rd_take && s_axi_araddr == `OFF_IN0) begin
            frozen <= 1'b1; // RL14
        end else if (rd_take && s_axi_araddr == `OFF_IN3) begin
            frozen <= 1'b0; // RL14
        end
    end
end

// ----------------------------------------------------------------
// axi4-lite write
// ----------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready        <= 1'b1;
        s_axi_wready         <= 1'b1;
        s_axi_bvalid         <= 1'b0;
        s_axi_bresp          <= 2'b00;
        aw_held              <= 1'b0;
        w_held               <= 1'b0;
        aw_addr              <= 8'h00;
        w_data               <= 32'h00000000;
        w_strb               <= 4'h0;
        ctrl                 <= `CTRL_RESET;
        edge_select_switches <= `EDGE_RESET;
        irq_en               <= `IRQ_EN_RESET;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(aw_addr) ? 2'b00 : 2'b10;
            if (aw_addr == `OFF_CTRL && w_strb[0]) begin
                ctrl <= w_data[4:0];
            end
            if (aw_addr == `OFF_EDGE && w_strb[0]) begin
                edge_select_switches <= w_data[7:0];
            end
            if (aw_addr == `OFF_IRQ_EN && w_strb[0]) begin
                irq_en <= w_data[2:0];
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// axi4-lite read
// ----------------------------------------------------------------
always @* begin
    case (s_axi_araddr)
        `OFF_IN0: begin
            rd_val = {24'h000000, stable[7:0]};
            // flag byte above the data only in the first-byte mode
            if (mode == `MODE_FIRST_BYTE && std_area && pending) begin
                rd_val[15:8] = `FIRST_BYTE_FLAG; // RL2 RL7
            end
        end
        `OFF_IN1:    rd_val = {24'h000000, stable[15:8]};
        `OFF_IN2:    rd_val = {24'h000000, stable[23:16]};
        `OFF_IN3:    rd_val = {24'h000000, stable[31:24]};
        `OFF_CTRL:   rd_val = {27'h0000000, ctrl};
        `OFF_EDGE:   rd_val = {24'h000000, edge_select_switches};
        `OFF_STATUS: rd_val = {29'h0, status};
        `OFF_IRQ_EN: rd_val = {29'h0, irq_en};
        `OFF_ALARM:  rd_val = {30'h0, frozen, pending};
        default:     rd_val = 32'h00000000;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= 2'b00;
    end else if (rd_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_val;
        s_axi_rresp   <= (is_mapped(s_axi_araddr) &&
                          s_axi_araddr != `OFF_IRQ_CLR) ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
    end
end

endmodule // change_detect_input_module

// file: tb/change_detect_checker.sv
`timescale 1ns/1ns
// ------
// bus and alarm checks
// ------
module change_detect_checker (
    input wire       aclk,
    input wire       aresetn,
    input wire       s_axi_awvalid,
    input wire       s_axi_awready,
    input wire       s_axi_wvalid,
    input wire       s_axi_wready,
    input wire       s_axi_bvalid,
    input wire       s_axi_bready,
    input wire       s_axi_arvalid,
    input wire       s_axi_arready,
    input wire [7:0] s_axi_araddr,
    input wire       s_axi_rvalid,
    input wire       s_axi_rready,
    input wire       alarm_req,
    input wire       irq
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // only the four aligned input words acknowledge
    wire in_rd = s_axi_arvalid && s_axi_arready &&
                 s_axi_araddr <= 8'h0c && s_axi_araddr[1:0] == 2'b00;
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence wr_idle;
        !s_axi_bvalid && s_axi_awready && s_axi_wready;
    endsequence
    reset_state_a:
    assert property (disable iff (1'b0) !aresetn |=> wr_idle ##0
        (s_axi_arready && !s_axi_rvalid && !alarm_req && !irq))
        else $error("outputs not idle after reset");
    write_resp_a:
    assert property (wr_taken |-> ##2 s_axi_bvalid)
        else $error("no write response");
    write_done_a:
    assert property (s_axi_bvalid && s_axi_bready |=> wr_idle)
        else $error("write channel not free again");
    aw_block_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_resp_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data");
    read_done_a:
    assert property (s_axi_rvalid && s_axi_rready |=>
        !s_axi_rvalid && s_axi_arready)
        else $error("read channel not free again");
    alarm_hold_a:
    assert property (alarm_req && !in_rd && !s_axi_awvalid |=> alarm_req)
        else $error("alarm dropped without read");
    read_ack_a:
    assert property (alarm_req && in_rd |=> !alarm_req)
        else $error("alarm kept after input read");
endmodule // change_detect_checker

bind change_detect_input_module change_detect_checker chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .alarm_req, .irq);

// file: tb/host_model.sv
`timescale 1ns/1ns
// ------
// controller side of the bus
// ------
module host_model (
    input  wire        aclk,
    output reg  [7:0]  s_axi_awaddr,
    output reg         s_axi_awvalid,
    input  wire        s_axi_awready,
    output reg  [31:0] s_axi_wdata,
    output reg  [3:0]  s_axi_wstrb,
    output reg         s_axi_wvalid,
    input  wire        s_axi_wready,
    input  wire [1:0]  s_axi_bresp,
    input  wire        s_axi_bvalid,
    output reg         s_axi_bready,
    output reg  [7:0]  s_axi_araddr,
    output reg         s_axi_arvalid,
    input  wire        s_axi_arready,
    input  wire [31:0] s_axi_rdata,
    input  wire [1:0]  s_axi_rresp,
    input  wire        s_axi_rvalid,
    output reg         s_axi_rready
);
    reg        hung = 0;
    reg        ad, dd;
    reg [31:0] img [0:3];
    integer    n;
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = 0;
    initial {s_axi_wvalid, s_axi_bready, s_axi_araddr} = 0;
    initial {s_axi_arvalid, s_axi_rready} = 0;
    task wr(input [7:0] a, input [31:0] d, output [1:0] r);
        begin
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_wstrb <= 4'hf;
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
            {ad, dd, n} = {2'h3, 32'h0};
            while ((ad || dd) && n < 99) begin
                @(posedge aclk);
                n = n + 1;
                ad = ad & ~s_axi_awready;
                dd = dd & ~s_axi_wready;
                s_axi_awvalid <= ad;
                s_axi_wvalid <= dd;
            end
            do begin @(posedge aclk); n = n + 1; end
            while (!s_axi_bvalid && n < 99);
            r = s_axi_bresp;
            s_axi_bready <= 0;
            hung = hung | (n >= 99);
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            {s_axi_arvalid, s_axi_rready} <= 2'h3;
            n = 0;
            do begin @(posedge aclk); n = n + 1; end
            while (!s_axi_arready && n < 99);
            s_axi_arvalid <= 0;
            do begin @(posedge aclk); n = n + 1; end
            while (!s_axi_rvalid && n < 99);
            {d, r} = {s_axi_rdata, s_axi_rresp};
            s_axi_rready <= 0;
            hung = hung | (n >= 99);
        end
    endtask
    // one uninterrupted handler; later alarms wait for it to finish
    task service;
        integer   i;
        reg [1:0] r;
        for (i = 0; i < 4; i = i + 1)
            rd(8'(4 * i), img[i], r);
    endtask
endmodule // host_model

// file: tb/testbench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons = comparisons + 1; \
    if ((g) !== (e)) begin mismatches = mismatches + 1; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    typedef struct packed {
        logic [7:0]  a;
        logic        we;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0]  rr;
    } row_t;
    reg         aclk = 0, aresetn = 0;
    reg  [31:0] process_in = 0, d;
    reg  [1:0]  r;
    wire [7:0]  s_axi_awaddr, s_axi_araddr;
    wire [31:0] s_axi_wdata, s_axi_rdata;
    wire [3:0]  s_axi_wstrb;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire        s_axi_rvalid, s_axi_rready, alarm_req, irq;
    integer     mismatches = 0, comparisons = 0, i, k;
    row_t       rows [0:6];
    // short filter counts keep the run brief
    change_detect_input_module #(.react_short_cyc(18'h4),
        .react_mid_cyc(18'h8), .react_long_cyc(18'h10)) uut (.*);
    host_model host (.*);
    always #10 aclk = ~aclk;
    always @(posedge aclk) if (host.hung) begin
        mismatches = mismatches + 1;
        end_sim;
    end
    task end_sim;
        begin
            $display("comparisons=%0d mismatches=%0d", comparisons,
                mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    // len 0 leaves the new level standing, else a pulse of len cycles
    task hit(input [31:0] v, input integer len, input e);
        begin
            @(posedge aclk);
            process_in <= v;
            if (len > 0) begin
                repeat (len) @(posedge aclk);
                process_in <= 32'h0;
            end
            repeat (30) @(posedge aclk);
            `CHK(alarm_req, e)
            host.service;
            `CHK(alarm_req, 1'b0)
        end
    endtask
    initial begin
        rows[0] = '{8'h10, 1'b0, 32'h0, 32'h0, 2'h0};
        rows[1] = '{8'h14, 1'b0, 32'h0, 32'h55, 2'h0};
        rows[2] = '{8'h1c, 1'b0, 32'h0, 32'h0, 2'h0};
        rows[3] = '{8'h28, 1'b1, 32'h1, 32'h0, 2'h2};
        rows[4] = '{8'h20, 1'b0, 32'h0, 32'h0, 2'h2};
        rows[5] = '{8'h1c, 1'b1, 32'h4, 32'h4, 2'h0};
        rows[6] = '{8'h18, 1'b1, 32'hff, 32'h0, 2'h0};
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        for (i = 0; i < 7; i = i + 1) begin
            if (rows[i].we) begin
                host.wr(rows[i].a, rows[i].wd, r);
                `CHK(r, rows[i].a > 8'h24 ? 2'h2 : 2'h0)
            end
            host.rd(rows[i].a, d, r);
            `CHK(d, rows[i].rd)
            `CHK(r, rows[i].rr)
            $display("row %0d done", i);
        end
        host.wr(8'h14, 32'hff, r);
        hit(32'h100, 0, 1'b0);
        host.wr(8'h14, 32'h55, r);
        host.wr(8'h10, 32'h1, r);
        hit(32'h0, 0, 1'b0);
        hit(32'h100, 0, 1'b1);
        `CHK(host.img[1], 32'h1)
        `CHK(irq, 1'b1)
        host.wr(8'h20, 32'h4, r);
        `CHK(irq, 1'b0)
        host.wr(8'h1c, 32'h0, r);
        host.wr(8'h14, 32'h8, r);
        hit(32'h0, 0, 1'b1);
        `CHK(irq, 1'b0)
        $display("mode and edge tests done");
        host.wr(8'h14, 32'h55, r);
        for (k = 0; k < 3; k = k + 1) begin
            host.wr(8'h10, {28'h0, k[1:0], 2'h1}, r);
            hit(32'h1, (4 << k) - 1, 1'b0);
            hit(32'h1, (4 << k) + 1, 1'b1);
        end
        $display("reaction time tests done");
        for (k = 0; k < 2; k = k + 1) begin
            host.wr(8'h10, k ? 32'h12 : 32'h2, r);
            process_in <= process_in | (32'h10000 << (8 * k));
            repeat (30) @(posedge aclk);
            host.service;
            `CHK(host.img[0][15:8], k ? 8'hff : 8'h00)
            host.service;
            `CHK(host.img[0][15:8], 8'h00)
        end
        $display("first byte tests done");
        host.wr(8'h10, 32'h1, r);
        host.rd(8'h0, d, r);
        process_in <= process_in | 32'h100;
        repeat (30) @(posedge aclk);
        `CHK(alarm_req, 1'b0)
        for (k = 1; k < 4; k = k + 1)
            host.rd(8'(4 * k), d, r);
        repeat (30) @(posedge aclk);
        `CHK(alarm_req, 1'b1)
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        `CHK(alarm_req, 1'b0)
        host.rd(8'h10, d, r);
        `CHK(d, 32'h0)
        $display("freeze and reset tests done");
        end_sim;
    end
endmodule // testbench
